// ### bridge_supervisory_registers_tb.sv
// self-checking bench of the bridge register bank over axi4-lite
`timescale 1ns/10ps
`include "bsr_defs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module bridge_supervisory_registers_tb
    import bsr_pkg::*;
;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, fwd_hit, fwd_req, fatal_evt, soft_evt;
    logic int_group_first, int_group_second, upstream_reset, pci_reset, err_log_stb;
    logic fast_b2b_enable, pci_port_wr;
    logic [31:0] awaddr, wdata, araddr, rdata, irq_lines, fwd_addr, pci_cfg_address_port;
    logic [31:0] pci_port_wdata, pci_port_rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, pci_port_sel;
    bsr_err_log_t err_log_in;
    int miscompares = 0, samples_checked = 0, cyc = 0, rst_seen = 0;
    // ident values are arbitrary
    bsr_regs #(.IDENT0(32'h12345678), .IDENT1_MODEL(20'h00ABC), .IDENT1_REV(4'h2)) dut (
        .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
        .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
        .rresp, .irq_lines, .int_group_first, .int_group_second, .fatal_evt, .soft_evt,
        .err_log_stb, .err_log_in, .fwd_req, .fwd_addr, .fwd_hit, .upstream_reset,
        .pci_reset, .fast_b2b_enable, .pci_cfg_address_port, .pci_port_wr, .pci_port_sel,
        .pci_port_wdata, .pci_port_rdata);
    bsr_pci_model far (.aclk, .aresetn, .pci_port_wr, .pci_port_wdata, .pci_port_rdata);
    // clock source
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // counts reset pulses sent upstream and to pci, and cuts a hang short
    always @(posedge aclk) begin
        cyc++;
        if (upstream_reset === 1'b1 && pci_reset === 1'b1) rst_seen++;
        if (cyc == 5000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("compares %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        awaddr <= {20'h00000, a};
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        `CHK(bresp, r)
        @(posedge aclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
        araddr <= {20'h00000, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        `CHK(rdata, e)
        `CHK(rresp, r)
        @(posedge aclk);
    endtask
    task automatic fwd(input logic [31:0] a, input logic e);
        fwd_addr <= a;
        fwd_req <= 1'b1;
        @(posedge aclk);
        fwd_req <= 1'b0;
        @(posedge aclk);
        `CHK(fwd_hit, e)
    endtask
    task automatic evt(input logic fatal);
        fatal_evt <= fatal;
        soft_evt <= !fatal;
        @(posedge aclk);
        fatal_evt <= 1'b0;
        soft_evt <= 1'b0;
        @(posedge aclk);
    endtask
    // main sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, fwd_req, fatal_evt} = '0;
        {soft_evt, err_log_stb, awaddr, wdata, araddr, irq_lines, fwd_addr, wstrb} = '0;
        err_log_in = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`BSR_OFF_STAT, 32'h00000040);
        wr(`BSR_OFF_STAT, 32'hFFFFFFFF, `BSR_RESP_SLVERR);
        rd(`BSR_OFF_STAT, 32'h00000040);
        rd(12'h0FC, 32'h00000000, `BSR_RESP_SLVERR);
        rd(`BSR_OFF_TOC, 32'hFFFA0030);
        wr(`BSR_OFF_TOC, 32'hFFFFFFFF);
        rd(`BSR_OFF_TOC, 32'hFFFBE030);
        wr(`BSR_OFF_IDENT, 32'h00000004);
        rd(`BSR_OFF_IDENT, 32'h200ABC00);
        wr(`BSR_OFF_IDENT, 32'h00000000);
        rd(`BSR_OFF_IDENT, 32'h12345678);
        wr(`BSR_OFF_INT_ADDRESS_GROUP1, 32'h0000A5C3);
        rd(`BSR_OFF_INT_ADDRESS_GROUP1, 32'h0000A5C3);
        wr(`BSR_OFF_CFGD, 32'h00C0FFEE);
        rd(`BSR_OFF_CFGD, 32'h00C0FFEE);
        `CHK(pci_port_sel, 2'h0)
        `CHK(pci_port_wdata, 32'h00C0FFEE)
        wr(`BSR_OFF_MEMD, 32'h0BADF00D);
        `CHK(pci_port_sel, 2'h2)
        rd(`BSR_OFF_IOD, 32'h0BADF00D);
        wr(`BSR_OFF_FBB, 32'h00000001);
        `CHK(fast_b2b_enable, 1'b1)
        wr(`BSR_OFF_CFGA, 32'h80001234);
        `CHK(pci_cfg_address_port, 32'h80001234)
        rd(`BSR_OFF_CFGA, 32'h80001234);
        err_log_in <= {32'h11110000, 32'h00000005, 32'h22220000};
        err_log_stb <= 1'b1;
        @(posedge aclk);
        err_log_stb <= 1'b0;
        rd(`BSR_OFF_ERESP, 32'h11110000);
        rd(`BSR_OFF_EINFO, 32'h00000005);
        rd(`BSR_OFF_EREQ, 32'h22220000);
        irq_lines <= 32'h00000001;
        repeat (6) @(posedge aclk);
        `CHK(int_group_first, 1'b0)
        rd(`BSR_OFF_ILR, 32'h00000001);
        wr(`BSR_OFF_IMR, 32'h00000001);
        `CHK(int_group_first, 1'b1)
        rd(`BSR_OFF_INT_REQUEST_GROUP0, 32'h00000001);
        wr(`BSR_OFF_ICR, 32'h00000001);
        repeat (2) @(posedge aclk);
        `CHK(int_group_second, 1'b1)
        rd(`BSR_OFF_INT_REQUEST_GROUP1, 32'h00000001);
        irq_lines <= 32'h00000000;
        wr(`BSR_OFF_IPR, 32'h00000001);
        rd(`BSR_OFF_IPR, 32'h00000000);
        wr(`BSR_OFF_WIN, 32'h00000002);
        wr(`BSR_OFF_CTL, 32'h00000001);
        fwd(32'hF0800000, 1'b1);
        fwd(32'hF1000000, 1'b0);
        fwd(32'hE0800000, 1'b0);
        wr(`BSR_OFF_CTL, 32'h00000002);
        fwd(32'hF0800000, 1'b0);
        wr(`BSR_OFF_CTL, 32'h00000001);
        wr(`BSR_OFF_CMD, 32'h00000005);
        repeat (16) @(posedge aclk);
        `CHK(rst_seen, 1)
        rd(`BSR_OFF_CTL, 32'h00000000);
        fwd(32'hF0800000, 1'b0);
        rd(`BSR_OFF_TOC, 32'hFFFBE030);
        evt(1'b0);
        rd(`BSR_OFF_STAT, 32'h00000640);
        wr(`BSR_OFF_CMD, 32'h00000007);
        rd(`BSR_OFF_STAT, 32'h00000640);
        wr(`BSR_OFF_CMD, 32'h00000003);
        rd(`BSR_OFF_STAT, 32'h00000040);
        evt(1'b1);
        rd(`BSR_OFF_STAT, 32'h00000CC0);
        wr(`BSR_OFF_CMD, 32'h00000003);
        rd(`BSR_OFF_STAT, 32'h000000C0);
        rd(`BSR_OFF_TOC, 32'hFFFBE030);
        report_and_stop();
    end
endmodule // bridge_supervisory_registers_tb

// ### bsr_defs.svh
// register offsets, field positions, reset values and codes of the bridge register bank
`ifndef BSR_DEFS_SVH
`define BSR_DEFS_SVH
`define BSR_OFF_INT_ADDRESS_GROUP0 12'h004
`define BSR_OFF_IDENT 12'h008
`define BSR_OFF_INT_REQUEST_GROUP0 12'h00C
`define BSR_OFF_INT_ADDRESS_GROUP1 12'h010
`define BSR_OFF_INT_REQUEST_GROUP1 12'h014
`define BSR_OFF_IMR 12'h018
`define BSR_OFF_IPR 12'h01C
`define BSR_OFF_TOC 12'h020
`define BSR_OFF_ICR 12'h024
`define BSR_OFF_ILR 12'h028
`define BSR_OFF_CMD 12'h030
`define BSR_OFF_STAT 12'h034
`define BSR_OFF_CTL 12'h038
`define BSR_OFF_ERESP 12'h040
`define BSR_OFF_EINFO 12'h044
`define BSR_OFF_EREQ 12'h048
`define BSR_OFF_FBB 12'h05C
`define BSR_OFF_WIN 12'h060
`define BSR_OFF_CFGA 12'h064
`define BSR_OFF_CFGD 12'h068
`define BSR_OFF_IOD 12'h06C
`define BSR_OFF_MEMD 12'h070
`define BSR_ADDR_W 12
`define BSR_ID1_OPT 8'h00
`define BSR_ID_SEL_BIT 2
`define BSR_TOC_FIXED 32'hFFFA0030
`define BSR_TOC_ID_LSB 13
`define BSR_CMD_RESET 4'h5
`define BSR_CMD_CLEAR 4'h3
`define BSR_MODE_OFF 2'h0
`define BSR_MODE_INCLUDE 2'h1
`define BSR_ESTAT_CLEAR 6'h00
`define BSR_ESTAT_LTF 6'h01
`define BSR_ESTAT_FATAL 6'h03
`define BSR_IO_SPACE 4'hF
`define BSR_WIN_LSB 23
`define BSR_WIN_RESET 32'h00000000
`define BSR_RESP_OKAY 2'h0
`define BSR_RESP_SLVERR 2'h2
`endif

// ### bsr_pci_model.sv
// far-side pci data port stand-in for the bridge register bank
`timescale 1ns/10ps
module bsr_pci_model
    import bsr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pci_port_wr,
    input wire logic [31:0] pci_port_wdata,
    output logic [31:0] pci_port_rdata
);
    // returns the last word posted to the port, a marker pattern before any write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pci_port_rdata <= 32'h5A5AA5A5;
        end else if (pci_port_wr) begin
            pci_port_rdata <= pci_port_wdata;
        end
    end
endmodule // bsr_pci_model

// ### bsr_pkg.sv
// types shared by the bridge register bank
package bsr_pkg;
    // status word layout, most significant field first
    typedef struct packed {
        logic [15:0] rsv_hi;
        logic [5:0] estat;
        logic soft_error_flag;
        logic hard_error_flag;
        logic fatal_error_flag;
        logic command_ready_flag;
        logic [1:0] rsv_lo;
        logic lower_port_flag;
        logic [2:0] pwr_stat;
    } bsr_status_t;
    // error log captured from the bridge datapath
    typedef struct packed {
        logic [31:0] resp_addr;
        logic [31:0] info;
        logic [31:0] req_addr;
    } bsr_err_log_t;
    typedef enum logic {BSR_PORT_IDLE, BSR_PORT_BUSY} bsr_port_t;
endpackage

// ### bsr_regs.sv
// supervisory and auxiliary register bank of the bus-to-pci bridge, axi4-lite slave
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "bsr_defs.svh"
module bsr_regs
    import bsr_pkg::*;
#(
    parameter int NINT = 32,
    parameter logic [31:0] IDENT0 = 32'h00000001, // arbitrary value
    parameter logic [19:0] IDENT1_MODEL = 20'h00001, // arbitrary value
    parameter logic [3:0] IDENT1_REV = 4'h0 // arbitrary value
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [31:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic [NINT-1:0] irq_lines,
    output logic int_group_first,
    output logic int_group_second,
    input wire logic fatal_evt,
    input wire logic soft_evt,
    input wire logic err_log_stb,
    input wire bsr_err_log_t err_log_in,
    input wire logic fwd_req,
    input wire logic [31:0] fwd_addr,
    output logic fwd_hit,
    output logic upstream_reset,
    output logic pci_reset,
    output logic fast_b2b_enable,
    output logic [31:0] pci_cfg_address_port,
    output logic pci_port_wr,
    output logic [1:0] pci_port_sel,
    output logic [31:0] pci_port_wdata,
    input wire logic [31:0] pci_port_rdata
);
    // byte-lane merge of a write into an old value
    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] st);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // io-space window hit for an address against the enable mask
    function automatic logic window_hit(input logic [31:0] addr, input logic [31:0] en);
        return (addr[31:28] == `BSR_IO_SPACE) && en[addr[`BSR_WIN_LSB +: 5]];
    endfunction

    logic awready_r, aw_held_r, wready_r, w_held_r, bvalid_r, arready_r, rvalid_r;
    logic [`BSR_ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r, rdata_r, rd_data;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r, wr_resp;
    logic rd_err;
    bsr_port_t wr_state_r;
    logic [NINT-1:0] irq_meta_r, irq_sync_r, irq_prev_r, irq_rise;
    logic [NINT-1:0] mask_r, pending_r, grp_r, ipr_clr, req0, req1;
    logic [31:0] int_address_group0_r, int_address_group1_r, win_en_r, cfga_r;
    logic [3:0] toc_id_r;
    logic ident_sel_r, fbb_r, fe_r, fwd_hit_r, up_rst_r, pci_rst_r;
    logic grp0_r, grp1_r, pwr_r;
    logic [1:0] mode_r, psel_r;
    logic [31:0] pwdata_r;
    logic [5:0] estat_r;
    bsr_err_log_t elog_r;
    bsr_status_t status_w;
    logic wr_go, wr_hit, rd_go, cmd_reset, cmd_clear;
    logic [3:0] cmd_code;

    assign wr_go = aw_held_r && w_held_r && (wr_state_r == BSR_PORT_IDLE);
    assign rd_go = arvalid && arready_r;
    assign cmd_code = wdata_r[3:0];
    assign cmd_reset = wr_go && awaddr_r == `BSR_OFF_CMD && wstrb_r[0]
                       && cmd_code == `BSR_CMD_RESET;
    assign cmd_clear = wr_go && awaddr_r == `BSR_OFF_CMD && wstrb_r[0]
                       && cmd_code == `BSR_CMD_CLEAR;

    // write address channel: hold one address until the write is done
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            awready_r <= 1'b0;
            awaddr_r <= '0;
        end else if (awvalid && awready_r) begin
            aw_held_r <= 1'b1;
            awready_r <= 1'b0;
            awaddr_r <= awaddr[`BSR_ADDR_W-1:0];
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
            awready_r <= 1'b1;
        end else if (!aw_held_r) begin
            awready_r <= 1'b1;
        end
    end

    // write data channel, taken independently of the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            wready_r <= 1'b0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else if (wvalid && wready_r) begin
            w_held_r <= 1'b1;
            wready_r <= 1'b0;
            wdata_r <= wdata;
            wstrb_r <= wstrb;
        end else if (wr_go) begin
            w_held_r <= 1'b0;
            wready_r <= 1'b1;
        end else if (!w_held_r) begin
            wready_r <= 1'b1;
        end
    end

    // write response decode: unmapped or read-only offsets answer slverr
    always_comb begin
        wr_hit = 1'b1;
        unique case (awaddr_r)
            `BSR_OFF_INT_ADDRESS_GROUP0, `BSR_OFF_IDENT, `BSR_OFF_INT_ADDRESS_GROUP1, `BSR_OFF_IMR, `BSR_OFF_IPR,
            `BSR_OFF_TOC, `BSR_OFF_ICR, `BSR_OFF_CMD, `BSR_OFF_CTL, `BSR_OFF_FBB,
            `BSR_OFF_WIN, `BSR_OFF_CFGA, `BSR_OFF_CFGD, `BSR_OFF_IOD,
            `BSR_OFF_MEMD: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
        wr_resp = wr_hit ? `BSR_RESP_OKAY : `BSR_RESP_SLVERR;
    end

    // write response channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_r <= BSR_PORT_IDLE;
            bvalid_r <= 1'b0;
            bresp_r <= `BSR_RESP_OKAY;
        end else begin
            unique case (wr_state_r)
                BSR_PORT_IDLE: begin
                    if (wr_go) begin
                        wr_state_r <= BSR_PORT_BUSY;
                        bvalid_r <= 1'b1;
                        bresp_r <= wr_resp;
                    end
                end
                BSR_PORT_BUSY: begin
                    if (bready) begin
                        wr_state_r <= BSR_PORT_IDLE;
                        bvalid_r <= 1'b0;
                    end
                end
            endcase
        end
    end

    // software-written configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_address_group0_r <= '0;
            int_address_group1_r <= '0;
            mask_r <= '0;
            grp_r <= '0;
            toc_id_r <= '0;
            ident_sel_r <= 1'b0;
            fbb_r <= 1'b0;
            win_en_r <= `BSR_WIN_RESET;
            cfga_r <= '0;
        end else if (wr_go) begin
            unique case (awaddr_r)
                `BSR_OFF_INT_ADDRESS_GROUP0: int_address_group0_r <= strb_merge(int_address_group0_r, wdata_r, wstrb_r);
                `BSR_OFF_INT_ADDRESS_GROUP1: int_address_group1_r <= strb_merge(int_address_group1_r, wdata_r, wstrb_r);
                `BSR_OFF_IMR: mask_r <= strb_merge(mask_r, wdata_r, wstrb_r);
                `BSR_OFF_ICR: grp_r <= strb_merge(grp_r, wdata_r, wstrb_r);
                `BSR_OFF_IDENT: begin
                    if (wstrb_r[0]) begin
                        ident_sel_r <= wdata_r[`BSR_ID_SEL_BIT];
                    end
                end
                `BSR_OFF_TOC: begin
                    if (wstrb_r[1]) begin
                        toc_id_r[2:0] <= wdata_r[15:13];
                    end
                    if (wstrb_r[2]) begin
                        toc_id_r[3] <= wdata_r[16];
                    end
                end
                `BSR_OFF_FBB: begin
                    if (wstrb_r[0]) begin
                        fbb_r <= wdata_r[0];
                    end
                end
                `BSR_OFF_WIN: begin
                    win_en_r <= strb_merge(win_en_r, wdata_r, wstrb_r)
                                & 32'h7FFFFFFE;
                end
                `BSR_OFF_CFGA: cfga_r <= strb_merge(cfga_r, wdata_r, wstrb_r);
                default: ;
            endcase
        end
    end

    // interrupt line synchroniser and edge detect
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_meta_r <= '0;
            irq_sync_r <= '0;
            irq_prev_r <= '0;
        end else begin
            irq_meta_r <= irq_lines;
            irq_sync_r <= irq_meta_r;
            irq_prev_r <= irq_sync_r;
        end
    end

    assign irq_rise = irq_sync_r & ~irq_prev_r;
    assign ipr_clr = (wr_go && awaddr_r == `BSR_OFF_IPR) ?
                     strb_merge('0, wdata_r, wstrb_r) : '0;
    assign req0 = pending_r & mask_r & ~grp_r;
    assign req1 = pending_r & mask_r & grp_r;

    // pending latch: write one clears, a new edge wins over the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending_r <= '0;
        end else begin
            pending_r <= (pending_r & ~ipr_clr) | irq_rise;
        end
    end

    // group interrupt request outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            grp0_r <= 1'b0;
            grp1_r <= 1'b0;
        end else begin
            grp0_r <= |req0;
            grp1_r <= |req1;
        end
    end

    // control mode and command pulses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r <= `BSR_MODE_OFF;
            up_rst_r <= 1'b0;
            pci_rst_r <= 1'b0;
        end else begin
            up_rst_r <= cmd_reset;
            pci_rst_r <= cmd_reset;
            if (cmd_reset) begin
                mode_r <= `BSR_MODE_OFF;
            end else if (wr_go && awaddr_r == `BSR_OFF_CTL && wstrb_r[0]) begin
                mode_r <= wdata_r[1:0];
            end
        end
    end

    // error severity, fatal flag; detected events win over a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            estat_r <= `BSR_ESTAT_CLEAR;
            fe_r <= 1'b0;
        end else begin
            if (fatal_evt) begin
                estat_r <= `BSR_ESTAT_FATAL;
                fe_r <= 1'b1;
            end else if (soft_evt && estat_r != `BSR_ESTAT_FATAL) begin
                estat_r <= `BSR_ESTAT_LTF;
            end else if (cmd_clear && !soft_evt) begin
                estat_r <= `BSR_ESTAT_CLEAR;
            end
        end
    end

    // error logging registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            elog_r <= '0;
        end else if (err_log_stb) begin
            elog_r <= err_log_in;
        end
    end

    // forwarding decision, one cycle after the request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fwd_hit_r <= 1'b0;
        end else begin
            fwd_hit_r <= fwd_req && mode_r == `BSR_MODE_INCLUDE
                         && window_hit(fwd_addr, win_en_r);
        end
    end

    // pci data port writes pass out as one-cycle strobes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwr_r <= 1'b0;
            psel_r <= 2'h0;
            pwdata_r <= '0;
        end else begin
            pwr_r <= wr_go && (awaddr_r == `BSR_OFF_CFGD || awaddr_r == `BSR_OFF_IOD
                               || awaddr_r == `BSR_OFF_MEMD);
            if (wr_go) begin
                psel_r <= awaddr_r[3:2] - 2'h2;
                pwdata_r <= wdata_r;
            end
        end
    end

    // status word assembly
    always_comb begin
        status_w = '0;
        status_w.estat = estat_r;
        status_w.soft_error_flag = (estat_r == `BSR_ESTAT_LTF);
        status_w.hard_error_flag = 1'b0;
        status_w.fatal_error_flag = fe_r;
        status_w.command_ready_flag = 1'b1;
        status_w.lower_port_flag = 1'b0;
        status_w.pwr_stat = 3'h0;
    end

    // read decode
    always_comb begin
        rd_data = '0;
        rd_err = 1'b0;
        unique case (araddr[`BSR_ADDR_W-1:0])
            `BSR_OFF_INT_ADDRESS_GROUP0: rd_data = int_address_group0_r;
            `BSR_OFF_IDENT: rd_data = ident_sel_r ?
                {IDENT1_REV, IDENT1_MODEL, `BSR_ID1_OPT} : IDENT0;
            `BSR_OFF_INT_REQUEST_GROUP0: rd_data = 32'(req0);
            `BSR_OFF_INT_ADDRESS_GROUP1: rd_data = int_address_group1_r;
            `BSR_OFF_INT_REQUEST_GROUP1: rd_data = 32'(req1);
            `BSR_OFF_IMR: rd_data = 32'(mask_r);
            `BSR_OFF_IPR: rd_data = 32'(pending_r);
            `BSR_OFF_TOC: rd_data = `BSR_TOC_FIXED
                                    | {15'h0, toc_id_r, 13'h0};
            `BSR_OFF_ICR: rd_data = 32'(grp_r);
            `BSR_OFF_ILR: rd_data = 32'(irq_sync_r);
            `BSR_OFF_CMD: rd_data = '0;
            `BSR_OFF_STAT: rd_data = status_w;
            `BSR_OFF_CTL: rd_data = {30'h0, mode_r};
            `BSR_OFF_ERESP: rd_data = elog_r.resp_addr;
            `BSR_OFF_EINFO: rd_data = elog_r.info;
            `BSR_OFF_EREQ: rd_data = elog_r.req_addr;
            `BSR_OFF_FBB: rd_data = {31'h0, fbb_r};
            `BSR_OFF_WIN: rd_data = win_en_r;
            `BSR_OFF_CFGA: rd_data = cfga_r;
            `BSR_OFF_CFGD, `BSR_OFF_IOD, `BSR_OFF_MEMD: rd_data = pci_port_rdata;
            default: rd_err = 1'b1;
        endcase
    end

    // read channel: data one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= `BSR_RESP_OKAY;
        end else if (rd_go) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_data;
            rresp_r <= rd_err ? `BSR_RESP_SLVERR : `BSR_RESP_OKAY;
        end else if (rvalid_r && rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end else if (!rvalid_r) begin
            arready_r <= 1'b1;
        end
    end

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign int_group_first = grp0_r;
    assign int_group_second = grp1_r;
    assign fwd_hit = fwd_hit_r;
    assign upstream_reset = up_rst_r;
    assign pci_reset = pci_rst_r;
    assign fast_b2b_enable = fbb_r;
    assign pci_cfg_address_port = cfga_r;
    assign pci_port_wr = pwr_r;
    assign pci_port_sel = psel_r;
    assign pci_port_wdata = pwdata_r;

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ident_word_a: assert property ((rd_go && araddr[11:0] == `BSR_OFF_IDENT && ident_sel_r)
        |=> rdata_r == {IDENT1_REV, IDENT1_MODEL, 8'h00})
        else $error("second ident word wrong");
    mask_reset_a: assert property ($rose(aresetn) |-> mask_r == '0)
        else $error("mask not clear after reset");
    pend_latch_a: assert property ((|irq_rise)
        |=> (pending_r & $past(irq_rise)) == $past(irq_rise))
        else $error("pending bit not latched");
    group_req_a: assert property ((pending_r & mask_r) == '0 |=> !int_group_first
        && !int_group_second)
        else $error("request without masked pending");
    toc_keep_a: assert property ((cmd_reset || cmd_clear) |=> $stable(toc_id_r))
        else $error("monarch id changed by command");
    reset_cmd_a: assert property (cmd_reset |=> mode_r == `BSR_MODE_OFF
        && upstream_reset && pci_reset ##1 !upstream_reset)
        else $error("reset command effect wrong");
    clear_cmd_a: assert property ((cmd_clear && !fatal_evt && !soft_evt)
        |=> estat_r == 6'h00 && !status_w.soft_error_flag)
        else $error("clear command did not clear");
    fatal_set_a: assert property (fatal_evt |=> fe_r && estat_r == 6'h03)
        else $error("fatal error not flagged");
    status_fixed_a: assert property (status_w[31:16] == 16'h0 && status_w[8] == 1'b0
        && status_w[6] && status_w[5:0] == 6'h00 && (estat_r == 6'h00 || estat_r == 6'h01
        || estat_r == 6'h03))
        else $error("status fixed bits wrong");
    soft_flag_a: assert property (((soft_evt && !fatal_evt && estat_r != 6'h03)
        |=> status_w.soft_error_flag) and (status_w.soft_error_flag |-> estat_r == 6'h01))
        else $error("soft flag outside soft mode");
    fwd_off_a: assert property (mode_r != 2'h1 |=> !fwd_hit)
        else $error("forward while not include");
    win_edges_a: assert property ((!win_en_r[0] && !win_en_r[31])
        and (fwd_hit |-> $past(win_en_r[fwd_addr[27:23]])))
        else $error("window decode wrong");

    reset_cmd_c: cover property (cmd_reset ##1 upstream_reset);
    int_req_c: cover property (|irq_rise ##[1:4] int_group_second);
    fwd_hit_c: cover property (fwd_req ##1 fwd_hit);
endmodule // bsr_regs
